// ==== verification/lswec_node.sv ====
// Purpose: far-side node on the single-wire link
// Assumes: wired-and bus with pull-up, low dominant
// Notes: answers a wake only when told to
`timescale 1ns/1ps
module lswec_node (
  // system
  input wire clk,
  // bench control
  input wire answer,
  input wire send,
  // bus
  input wire dut_tx,
  output wire bus
);
  reg [3:0] cnt = 4'h0;
  reg tx_q = 1'b1;
  // released line rests at the pull-up level
  assign bus = dut_tx & (cnt == 4'h0);
  always @(posedge clk) begin
    tx_q <= dut_tx;
    if (cnt != 4'h0) cnt <= cnt - 4'h1;
    else if (send) cnt <= 4'hA;
    else if (answer && dut_tx && !tx_q) cnt <= 4'h3;
  end
endmodule // lswec_node

// ==== verification/lswec_props.sv ====
// Purpose: port checks for lswec_top
// Assumes: NRST synchronous, one clock
// Notes: cfg mirrors writes to the config register
`timescale 1ns/1ps
module lswec_props #(
  parameter [31:0] WAKE_CYC = 32'd8
) (
  // system
  input wire CLK,
  input wire NRST,
  // register port
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  // frame engine, bus, interrupt
  input wire FRAME_ERROR,
  input wire FRAME_ABORT,
  input wire MASTER_START,
  input wire AUTO_RATE,
  input wire BUS_TX,
  input wire IRQ
);
  // ==========================================
  // helpers
  reg [2:0] cfg;
  reg [31:0] low;
  wire wr8 = REG_WR && REG_ADDR == 8'hC8;
  always @(posedge CLK) begin
    if (!NRST) cfg <= 3'h3;
    else if (REG_WR && REG_ADDR == 8'hC9) cfg <= REG_WDATA[7:5];
  end
  // counts sampled low cycles of the wake pulse
  always @(posedge CLK) begin
    if (!NRST || BUS_TX) low <= 32'h0;
    else low <= low + 32'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ==========================================
  // properties
  property p_cfg_rd;
    REG_RD && !REG_WR && REG_ADDR == 8'hC9 |=> REG_RDATA == {cfg, 5'h0};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("config read wrong");
  property p_auto;
    $stable(cfg) |-> AUTO_RATE == (cfg[0] && !cfg[1]);
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto rate level wrong");
  property p_wake_len;
    $rose(BUS_TX) |-> low == WAKE_CYC;
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("wake pulse length wrong");
  property p_wake_cause;
    $fell(BUS_TX) |-> $past(wr8 && REG_WDATA[1]);
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake pulse without request");
  property p_wake_off;
    wr8 && REG_WDATA[1] && !cfg[2] && BUS_TX |=> BUS_TX;
  endproperty
  a_wake_off: assert property (p_wake_off)
    else $error("wake sent while disabled");
  property p_start_cause;
    MASTER_START |-> $past(wr8 && REG_WDATA[0] && cfg[2] && cfg[1]);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without enabled master write");
  property p_start_pulse;
    MASTER_START |=> !MASTER_START;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start not a single pulse");
  property p_abort;
    FRAME_ERROR |=> FRAME_ABORT;
  endproperty
  a_abort: assert property (p_abort)
    else $error("no abort after error");
  property p_err_irq;
    FRAME_ERROR |-> ##[1:2] IRQ;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("no interrupt after error");
  c_wake: cover property ($rose(BUS_TX));
  c_abort: cover property (FRAME_ABORT);
  c_start: cover property (MASTER_START);
endmodule // lswec_props
bind lswec_top lswec_props #(.WAKE_CYC(WAKE_CYC)) u_props (
  .CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .FRAME_ERROR(FRAME_ERROR), .FRAME_ABORT(FRAME_ABORT),
  .MASTER_START(MASTER_START), .AUTO_RATE(AUTO_RATE),
  .BUS_TX(BUS_TX), .IRQ(IRQ)
);

// ==== verification/lswec_top_tb.sv ====
// Purpose: self-checking bench for lswec_top
// Assumes: short counts 50, 40, 8, 6 cycles
// Notes: status bits except error cleared by writing ones
`timescale 1ns/1ps
module lswec_top_tb;
  localparam [31:0] WK = 32'd8;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] addr = 8'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] wdata = 8'h0;
  reg ferr = 1'b0;
  reg [7:0] fcode = 8'h0;
  reg answer = 1'b0;
  reg send = 1'b0;
  wire [7:0] rdata;
  wire fabort, mstart, arate, tx, irq, rx;
  reg [7:0] q;
  integer err_count = 0;
  integer total_checks = 0;
  integer n;
  always #2 clk = ~clk;
  lswec_top #(.IDLE_CYC(32'd50), .RESP_CYC(32'd40), .WAKE_CYC(WK),
    .WDET_CYC(32'd6)) uut (.CLK(clk), .NRST(nrst), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .FRAME_ERROR(ferr), .FRAME_ERROR_CODE(fcode), .FRAME_ABORT(fabort),
    .MASTER_START(mstart), .AUTO_RATE(arate), .BUS_RX(rx), .BUS_TX(tx),
    .IRQ(irq));
  lswec_node node (.clk(clk), .answer(answer), .send(send),
    .dut_tx(tx), .bus(rx));
  // ==========================================
  // shared tasks
  task chk(input [79:0] nm, input [7:0] seen, input [7:0] exp);
    if (seen !== exp) begin
      $display("BAD %0s exp %h seen %h", nm, exp, seen);
      err_count = err_count + 1;
    end
  endtask
  task wrr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rdr(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdata;
      total_checks = total_checks + 1;
    end
  endtask
  // bounded wait; n counts cycles spent
  task till(input [7:0] max, input want);
    for (n = 0; n < max && (want ? irq : tx) !== want; n = n + 1)
      @(posedge clk) #1;
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // ==========================================
  // scenarios
  task t_cfg;
    begin
      rdr(8'hC9);
      chk("cfg rst", q, 8'h60);
      wrr(8'hC9, 8'hBF);
      rdr(8'hC9);
      chk("cfg ro", q, 8'hA0);
      chk("auto", {7'h0, arate}, 8'h1);
      $display("end cfg");
    end
  endtask
  task t_mwake;
    begin
      wrr(8'hC9, 8'hC0);
      wrr(8'hCA, 8'hFF);
      wrr(8'hC8, 8'h02);
      till(8'd4, 1'b0);
      // first low cycle is already behind us when this loop starts
      for (n = 1; tx === 1'b0 && n < 40; n = n + 1) @(posedge clk) #1;
      chk("wake len", n, WK);
      till(8'd4, 1'b1);
      rdr(8'hCA);
      chk("done", {7'h0, q[0]}, 8'h1);
      $display("end master wake");
    end
  endtask
  task t_swake(input ans);
    begin
      answer <= ans;
      wrr(8'hC9, 8'h80);
      wrr(8'hC8, 8'h02);
      repeat (60) @(posedge clk);
      rdr(8'hCA);
      chk("st err", {7'h0, q[2]}, {7'h0, !ans});
      rdr(8'hCB);
      chk("response_timeout_error", {7'h0, q[2]}, {7'h0, !ans});
      wrr(8'hC8, 8'h04);
      $display("end slave wake");
    end
  endtask
  task t_err;
    begin
      @(posedge clk);
      ferr <= 1'b1;
      fcode <= 8'h01;
      @(posedge clk);
      ferr <= 1'b0;
      till(8'd4, 1'b1);
      rdr(8'hCB);
      chk("err reg", {7'h0, q[0]}, 8'h1);
      wrr(8'hC9, 8'hC0);
      wrr(8'hC8, 8'h03);
      for (n = 0; n < 12; n = n + 1) @(posedge clk) #1
        chk("refuse", {6'h0, mstart, !tx}, 8'h0);
      wrr(8'hC8, 8'h04);
      rdr(8'hCB);
      chk("err clr", q, 8'h0);
      rdr(8'hCA);
      chk("flag clr", {7'h0, q[2]}, 8'h0);
      wrr(8'hC8, 8'h01);
      #1 chk("start", {7'h0, mstart}, 8'h1);
      $display("end error");
    end
  endtask
  task t_det;
    begin
      wrr(8'hCA, 8'hFF);
      @(posedge clk);
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      // fixed wait: an idle interrupt may pulse before the detect
      repeat (20) @(posedge clk);
      rdr(8'hCA);
      chk("wake det", {6'h0, q[1:0]}, 8'h3);
      wrr(8'hC8, 8'h00);
      $display("end detect");
    end
  endtask
  task t_idle(input [7:0] slp);
    begin
      wrr(8'hC8, slp);
      wrr(8'hCA, 8'hFF);
      repeat (60) @(posedge clk);
      rdr(8'hCA);
      chk("idle", {7'h0, q[6]}, {7'h0, !slp[6]});
      $display("end idle");
    end
  endtask
  initial begin
    #20000;
    err_count = err_count + 1;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_cfg;
    t_mwake;
    t_swake(1'b0);
    t_swake(1'b1);
    t_err;
    t_det;
    t_idle(8'h00);
    t_idle(8'h40);
    print_verdict;
  end
endmodule // lswec_top_tb

// ==== verilog/lswec_defs.vh ====
// Purpose: constants for the link sleep, wake and error control block
// Assumes: 250 MHz system clock, 8-bit register port
// Notes: timing counts derive from times in their own units
`ifndef LSWEC_DEFS_VH
`define LSWEC_DEFS_VH

`define LSWEC_CLK_MHZ 250
// config register
`define LSWEC_CFG_ADDR 8'hC9
`define LSWEC_CFG_RESET 8'h60
`define LSWEC_CFG_EN_BIT 7
`define LSWEC_CFG_MASTER_BIT 6
`define LSWEC_CFG_AUTO_BIT 5
// block-local control, status, error registers
`define LSWEC_CTRL_ADDR 8'hC8
`define LSWEC_STAT_ADDR 8'hCA
`define LSWEC_ERR_ADDR 8'hCB
`define LSWEC_CTRL_SLEEP_BIT 6
`define LSWEC_CTRL_CLRERR_BIT 2
`define LSWEC_CTRL_WAKE_BIT 1
`define LSWEC_CTRL_START_BIT 0
`define LSWEC_ST_IDLE_BIT 6
`define LSWEC_ST_ERROR_BIT 2
`define LSWEC_ST_WAKEUP_BIT 1
`define LSWEC_ST_DONE_BIT 0
`define LSWEC_ERR_RESPONSE_TIMEOUT_ERROR_BIT 2
// times and counts
`define LSWEC_IDLE_TIME_S 4
`define LSWEC_IDLE_CYC (`LSWEC_IDLE_TIME_S * 1000000 * `LSWEC_CLK_MHZ)
`define LSWEC_RESP_TIME_MS 150
`define LSWEC_RESP_CYC (`LSWEC_RESP_TIME_MS * 1000 * `LSWEC_CLK_MHZ)
`define LSWEC_WAKE_TIME_US 250
`define LSWEC_WAKE_CYC (`LSWEC_WAKE_TIME_US * `LSWEC_CLK_MHZ)
`define LSWEC_WDET_TIME_US 150
`define LSWEC_WDET_CYC (`LSWEC_WDET_TIME_US * `LSWEC_CLK_MHZ)

`endif

// ==== verilog/lswec_timer.v ====
// Purpose: restartable timeout counter with one-cycle expiry pulse
// Assumes: limit at least 1
// Notes: holds at zero while not running
`timescale 1ns/1ps
module lswec_timer #(
  parameter [31:0] LIMIT = 32'd10
) (
  input wire clk,
  input wire nrst,
  input wire run,
  input wire restart,
  output reg expire
);
  reg [31:0] count;

  always @(posedge clk) begin
    if (!nrst) begin
      count <= 32'h0000_0000;
      expire <= 1'b0;
    end else if (!run || restart) begin
      count <= 32'h0000_0000;
      expire <= 1'b0;
    end else if (count == LIMIT - 32'd1) begin
      // one pulse, then rearm
      count <= 32'h0000_0000;
      expire <= 1'b1;
    end else begin
      count <= count + 32'd1;
      expire <= 1'b0;
    end
  end
endmodule // lswec_timer

// ==== verilog/lswec_top.v ====
// Purpose: sleep, wake-up and error control of a single-wire link
// Assumes: register port synchronous, one access per cycle
// Notes: frame engine outside reports errors and error codes
//
// How it works
// - four seconds quiet while awake flags timeout
// - wake request bit drives wake pulse out
// - master wake sent sets done, interrupts
// - slave wake unanswered 150 ms flags timeout error
// - detected wake sets wakeup, done, interrupt
// - any error aborts frame, raises interrupt
// - error clear strobe wipes error register, flag
// - error flag blocks master start and wake
// - config bit 7 enables, resets zero
// - config bit 6 master role, resets one
// - config bit 5 auto rate, slave only
// - config bits 4 to 0 read zero
`timescale 1ns/1ps
`include "lswec_defs.vh"
module lswec_top #(
  parameter [31:0] IDLE_CYC = `LSWEC_IDLE_CYC,
  parameter [31:0] RESP_CYC = `LSWEC_RESP_CYC,
  parameter [31:0] WAKE_CYC = `LSWEC_WAKE_CYC,
  parameter [31:0] WDET_CYC = `LSWEC_WDET_CYC
) (
  // system
  input wire CLK,
  input wire NRST,
  // register port
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  // frame engine
  input wire FRAME_ERROR,
  input wire [7:0] FRAME_ERROR_CODE,
  output reg FRAME_ABORT,
  output reg MASTER_START,
  output reg AUTO_RATE,
  // bus
  input wire BUS_RX,
  output reg BUS_TX,
  // interrupt
  output reg IRQ
);
  // ==========================================================
  // registers
  reg interface_enable_bit;
  reg master_mode;
  reg auto_rate_select;
  reg sleep_bit;
  reg bus_quiet_timeout_flag;
  reg error_flag;
  reg wakeup_flag;
  reg done_flag;
  reg [7:0] link_error_reg;
  reg rx_prev;
  reg waking;
  reg wait_resp;
  reg [31:0] wake_count;

  wire wr_ctrl = REG_WR && (REG_ADDR == `LSWEC_CTRL_ADDR);
  wire wr_cfg = REG_WR && (REG_ADDR == `LSWEC_CFG_ADDR);
  wire wr_stat = REG_WR && (REG_ADDR == `LSWEC_STAT_ADDR);
  wire error_clear_strobe = wr_ctrl &&
    REG_WDATA[`LSWEC_CTRL_CLRERR_BIT];
  wire wake_transmit_request = wr_ctrl &&
    REG_WDATA[`LSWEC_CTRL_WAKE_BIT];
  wire start_req = wr_ctrl && REG_WDATA[`LSWEC_CTRL_START_BIT];
  wire rx_edge = BUS_RX ^ rx_prev;
  // only a dominant edge answers a wake; our own release is a rise
  wire rx_fall = rx_prev && !BUS_RX;

  // ==========================================================
  // timers
  wire idle_hit;
  wire resp_hit;
  wire wake_seen;
  wire wake_done = waking && (wake_count == WAKE_CYC - 32'd1);
  // rx edges and own wake pulse count as activity
  lswec_timer #(.LIMIT(IDLE_CYC)) u_idle (
    .clk(CLK),
    .nrst(NRST),
    .run(interface_enable_bit && !sleep_bit),
    .restart(rx_edge || waking),
    .expire(idle_hit)
  );
  lswec_timer #(.LIMIT(RESP_CYC)) u_resp (
    .clk(CLK),
    .nrst(NRST),
    .run(wait_resp),
    .restart(1'b0),
    .expire(resp_hit)
  );
  // own wake pulse is not mistaken for a remote one
  lswec_wake_det #(.MIN_LOW(WDET_CYC)) u_wdet (
    .clk(CLK),
    .nrst(NRST),
    .enable(interface_enable_bit && !waking),
    .rx(BUS_RX),
    .detect(wake_seen)
  );

  // ==========================================================
  // wake transmit and response wait
  always @(posedge CLK) begin
    if (!NRST) begin
      waking <= 1'b0;
      wait_resp <= 1'b0;
      wake_count <= 32'h0000_0000;
      BUS_TX <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= BUS_RX;
      if (!interface_enable_bit) begin
        waking <= 1'b0;
        wait_resp <= 1'b0;
        wake_count <= 32'h0000_0000;
        BUS_TX <= 1'b1;
      end else if (!waking && wake_transmit_request &&
                   !error_flag) begin
        waking <= 1'b1;
        wait_resp <= 1'b0;
        wake_count <= 32'h0000_0000;
        BUS_TX <= 1'b0;
      end else if (waking) begin
        if (wake_done) begin
          waking <= 1'b0;
          BUS_TX <= 1'b1;
          wait_resp <= !master_mode;
        end else begin
          wake_count <= wake_count + 32'd1;
        end
      end else if (wait_resp && (rx_fall || resp_hit)) begin
        // any master traffic counts as a response
        wait_resp <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status and error flags, set wins over clear
  wire err_event = FRAME_ERROR || (wait_resp && resp_hit && !rx_fall);
  wire idle_set = idle_hit && !sleep_bit;
  wire done_set = (wake_done && master_mode) || wake_seen;
  always @(posedge CLK) begin
    if (!NRST) begin
      bus_quiet_timeout_flag <= 1'b0;
      error_flag <= 1'b0;
      wakeup_flag <= 1'b0;
      done_flag <= 1'b0;
      link_error_reg <= 8'h00;
      FRAME_ABORT <= 1'b0;
      MASTER_START <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      // status idle, wakeup or done bit written with one clears that flag
      if (idle_set)
        bus_quiet_timeout_flag <= 1'b1;
      else if (wr_stat && REG_WDATA[`LSWEC_ST_IDLE_BIT])
        bus_quiet_timeout_flag <= 1'b0;
      if (wake_seen)
        wakeup_flag <= 1'b1;
      else if (wr_stat && REG_WDATA[`LSWEC_ST_WAKEUP_BIT])
        wakeup_flag <= 1'b0;
      if (done_set)
        done_flag <= 1'b1;
      else if (wr_stat && REG_WDATA[`LSWEC_ST_DONE_BIT])
        done_flag <= 1'b0;
      if (err_event) begin
        error_flag <= 1'b1;
        link_error_reg <= link_error_reg | FRAME_ERROR_CODE |
          ((wait_resp && resp_hit && !rx_fall) ? 8'h04 : 8'h00);
      end else if (error_clear_strobe) begin
        error_flag <= 1'b0;
        link_error_reg <= 8'h00;
      end
      FRAME_ABORT <= err_event;
      MASTER_START <= start_req && master_mode &&
        interface_enable_bit && !error_flag;
      IRQ <= idle_set || done_set || err_event;
    end
  end

  // ==========================================================
  // control and config registers
  always @(posedge CLK) begin
    if (!NRST) begin
      interface_enable_bit <= 1'b0;
      master_mode <= 1'b1;
      auto_rate_select <= 1'b1;
      sleep_bit <= 1'b0;
      AUTO_RATE <= 1'b0;
    end else begin
      if (wr_cfg) begin
        interface_enable_bit <= REG_WDATA[`LSWEC_CFG_EN_BIT];
        master_mode <= REG_WDATA[`LSWEC_CFG_MASTER_BIT];
        auto_rate_select <= REG_WDATA[`LSWEC_CFG_AUTO_BIT];
      end
      if (wr_ctrl)
        sleep_bit <= REG_WDATA[`LSWEC_CTRL_SLEEP_BIT];
      AUTO_RATE <= auto_rate_select && !master_mode;
    end
  end

  // ==========================================================
  // read port, registered
  always @(posedge CLK) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `LSWEC_CFG_ADDR:
          REG_RDATA <= {interface_enable_bit, master_mode,
            auto_rate_select, 5'b00000};
        `LSWEC_CTRL_ADDR:
          REG_RDATA <= {1'b0, sleep_bit, 6'b000000};
        `LSWEC_STAT_ADDR:
          REG_RDATA <= {1'b0, bus_quiet_timeout_flag, 3'b000,
            error_flag, wakeup_flag, done_flag};
        `LSWEC_ERR_ADDR:
          REG_RDATA <= link_error_reg;
        default:
          REG_RDATA <= 8'h00;
      endcase
    end
  end
endmodule // lswec_top

// ==== verilog/lswec_wake_det.v ====
// Purpose: detect a dominant wake pulse on the bus receive line
// Assumes: rx already synchronous, low is dominant
// Notes: pulse fires once when low has lasted the minimum
`timescale 1ns/1ps
module lswec_wake_det #(
  parameter [31:0] MIN_LOW = 32'd10
) (
  input wire clk,
  input wire nrst,
  input wire enable,
  input wire rx,
  output reg detect
);
  reg [31:0] low_count;

  always @(posedge clk) begin
    if (!nrst) begin
      low_count <= 32'h0000_0000;
      detect <= 1'b0;
    end else if (!enable || rx) begin
      low_count <= 32'h0000_0000;
      detect <= 1'b0;
    end else begin
      if (low_count != MIN_LOW)
        low_count <= low_count + 32'd1;
      detect <= (low_count == MIN_LOW - 32'd1);
    end
  end
endmodule // lswec_wake_det
